// *** hw/edb_defines.vh ***
// constants for the ecc dram board datapath
`ifndef EDB_DEFINES_VH
`define EDB_DEFINES_VH
`define EDB_CLK_MHZ        20
`define EDB_T_ROW_SET_NS   50
`define EDB_T_ROW_HOLD_NS  50
`define EDB_T_COL_SET_NS   50
`define EDB_T_CAS_ACC_NS   150
`define EDB_T_PRECHG_NS    100
`define EDB_ADDR_W         22
`define EDB_DATA_W         16
`define EDB_CHK_W          6
`define EDB_WORD_W         22
`define EDB_RA_W           9
`define EDB_BYTE_BIT       0
`define EDB_WORD_BIT       1
`define EDB_ROW_LSB        2
`define EDB_COL_LSB        11
`define EDB_BANK_BIT       20
`define EDB_SPAN_BIT       21
`endif

// *** hw/edb_datapath.v ***
// ecc dram board datapath: address decode, ras/cas sequencing, ecc read/write
`timescale 1ns/1ps
`include "edb_defines.vh"
//
// Overview of operation
// RQ1: compare 22-bit address against board start address
// RQ2: pmi hit answers with selected signal
// RQ3: qbus hit runs cycle without select response
// RQ4: nine row bits, nine column bits
// RQ5: ras after stable row, then column address
// RQ6: cas only after column address stable
// RQ7: word is 16 data plus 6 check
// RQ8: four blocks, word and bank select
// RQ9: processor selects target block on writes
// RQ10: reads fetch even and odd words together
// RQ11: latch both words after cas access
// RQ12: qbus read returns word_select_bit word
// RQ13: qbus correction adds no access time
// RQ14: pmi returns selected word first, other second
// RQ15: pmi first-word error stalls; second does not
// RQ16: word write generates checks, one block strobed
// RQ17: word_select_bit picks block 0 or 1, or block 2 or 3 when bank_select_bit is set
// RQ18: byte write reads and corrects word first
// RQ19: merge byte, new checks, write back
// RQ20: byte_select_bit steers which byte merges
// RQ21: double error writes back unchanged word
// RQ22: delays counted in whole clock cycles
//
module edb_datapath #(
    parameter ROW_SET_CYC  = (`EDB_T_ROW_SET_NS  * `EDB_CLK_MHZ + 999) / 1000,
    parameter ROW_HOLD_CYC = (`EDB_T_ROW_HOLD_NS * `EDB_CLK_MHZ + 999) / 1000,
    parameter COL_SET_CYC  = (`EDB_T_COL_SET_NS  * `EDB_CLK_MHZ + 999) / 1000,
    parameter CAS_ACC_CYC  = (`EDB_T_CAS_ACC_NS  * `EDB_CLK_MHZ + 999) / 1000,
    parameter PRECHG_CYC   = (`EDB_T_PRECHG_NS   * `EDB_CLK_MHZ + 999) / 1000
) (
    input  wire                    clk_sys,        // board clock
    input  wire                    rst_n,          // sync reset, active low
    input  wire                    req_start,      // one-cycle request pulse
    input  wire                    req_write,      // 1 write, 0 read
    input  wire                    req_byte,       // byte write when writing
    input  wire                    req_pmi,        // 1 pmi protocol, 0 qbus
    input  wire [`EDB_ADDR_W-1:0]  req_addr,       // bus byte address
    input  wire [`EDB_DATA_W-1:0]  req_wdata,      // bus write data
    input  wire [`EDB_ADDR_W-1:0]  start_addr,     // board start address
    input  wire [`EDB_WORD_W-1:0]  ram_rdata_even, // block 0 / 2 data
    input  wire [`EDB_WORD_W-1:0]  ram_rdata_odd,  // block 1 / 3 data
    output reg  [`EDB_RA_W-1:0]    ram_addr_q,     // multiplexed ram address
    output reg  [1:0]              ras_n_q,        // row strobe per block pair
    output reg                     cas_n_q,        // column strobe
    output reg  [3:0]              we_n_q,         // write strobe per block
    output reg  [`EDB_WORD_W-1:0]  ram_wdata_q,    // data plus check bits
    output reg                     selected_q,     // pmi selected answer
    output reg                     busy_q,         // cycle in progress
    output reg  [`EDB_DATA_W-1:0]  rd_data_q,      // corrected read word
    output reg                     rd_valid_q,     // read word strobe
    output reg                     rd_err_q,       // uncorrectable with word
    output reg                     done_q          // cycle finished pulse
);

    ////////////////////////////////////////////////////////////////////////
    // states and widths
    localparam S_IDLE  = 4'd0;
    localparam S_ROW   = 4'd1;
    localparam S_RAS   = 4'd2;
    localparam S_COL   = 4'd3;
    localparam S_CAS   = 4'd4;
    localparam S_LATCH = 4'd5;
    localparam S_FIX   = 4'd6;
    localparam S_SEC   = 4'd7;
    localparam S_MERGE = 4'd8;
    localparam S_WCAS  = 4'd9;
    localparam S_PRE   = 4'd10;
    localparam CW      = 8;

    ////////////////////////////////////////////////////////////////////////
    // check-bit code of each data bit (unique, weight two or more)
    function [4:0] edb_code;
        input [3:0] i;
        begin
            case (i)
                4'd0:    edb_code = 5'd3;
                4'd1:    edb_code = 5'd5;
                4'd2:    edb_code = 5'd6;
                4'd3:    edb_code = 5'd7;
                4'd4:    edb_code = 5'd9;
                4'd5:    edb_code = 5'd10;
                4'd6:    edb_code = 5'd11;
                4'd7:    edb_code = 5'd12;
                4'd8:    edb_code = 5'd13;
                4'd9:    edb_code = 5'd14;
                4'd10:   edb_code = 5'd15;
                4'd11:   edb_code = 5'd17;
                4'd12:   edb_code = 5'd18;
                4'd13:   edb_code = 5'd19;
                4'd14:   edb_code = 5'd20;
                default: edb_code = 5'd21;
            endcase
        end
    endfunction

    // six check bits: five hamming plus overall parity
    function [`EDB_CHK_W-1:0] edb_gen;
        input [`EDB_DATA_W-1:0] d;
        integer k;
        reg [4:0] h;
        begin
            h = 5'd0;
            for (k = 0; k < `EDB_DATA_W; k = k + 1) begin
                if (d[k]) begin
                    h = h ^ edb_code(k[3:0]);
                end
            end
            edb_gen = {(^d) ^ (^h), h};
        end
    endfunction

    // correct one stored word: {double, any error, data}
    function [`EDB_DATA_W+1:0] edb_fix;
        input [`EDB_WORD_W-1:0] w;
        integer k;
        reg [4:0]  s;
        reg        p;
        reg [`EDB_DATA_W-1:0] d;
        reg [`EDB_CHK_W-1:0]  g;
        begin
            d = w[`EDB_DATA_W-1:0];
            g = edb_gen(d);
            s = g[4:0] ^ w[`EDB_DATA_W+4:`EDB_DATA_W];
            p = ^w;
            for (k = 0; k < `EDB_DATA_W; k = k + 1) begin
                if (p && (s == edb_code(k[3:0]))) begin
                    d[k] = ~d[k];
                end
            end
            edb_fix = {(~p) & (|s), p | (|s), d};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // address decode
    wire [`EDB_ADDR_W-1:0] off_w = req_addr - start_addr;
    wire hit_w = (req_addr >= start_addr) && !off_w[`EDB_SPAN_BIT]; // [RQ1]

    // captured request
    reg [`EDB_RA_W-1:0]   row_q;       // row address
    reg [`EDB_RA_W-1:0]   col_q;       // column address
    reg                   bank_q;      // bank_select_bit
    reg                   wsel_q;      // word_select_bit
    reg                   bsel_q;      // byte_select_bit
    reg                   wr_q;        // write cycle
    reg                   byte_q;      // byte write
    reg                   pmi_q;       // pmi protocol
    reg [`EDB_DATA_W-1:0] wdat_q;      // bus write data
    reg [`EDB_WORD_W-1:0] lat_e_q;     // latched even word
    reg [`EDB_WORD_W-1:0] lat_o_q;     // latched odd word
    reg [3:0]             st_q;        // sequencer state
    reg [CW-1:0]          cnt_q;       // delay counter

    // correction of both latched words, combinational
    wire [`EDB_DATA_W+1:0] fix_e_w = edb_fix(lat_e_q);
    wire [`EDB_DATA_W+1:0] fix_o_w = edb_fix(lat_o_q);
    wire [`EDB_DATA_W+1:0] fst_w   = wsel_q ? fix_o_w : fix_e_w; // [RQ12]
    wire [`EDB_DATA_W+1:0] sec_w   = wsel_q ? fix_e_w : fix_o_w; // [RQ14]
    wire [`EDB_WORD_W-1:0] raw_w   = wsel_q ? lat_o_q : lat_e_q;

    // byte merge of corrected word with bus byte
    wire [`EDB_DATA_W-1:0] mem_w = fst_w[`EDB_DATA_W-1:0];
    wire [`EDB_DATA_W-1:0] mrg_w = bsel_q ?
        {wdat_q[15:8], mem_w[7:0]} : {mem_w[15:8], wdat_q[7:0]}; // [RQ20]

    // one-hot write strobe of the addressed block, active low
    wire [3:0] blk_n_w = ~(4'h1 << {bank_q, wsel_q}); // [RQ8] [RQ17]

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q        <= S_IDLE;
            cnt_q       <= {CW{1'b0}};
            ram_addr_q  <= {`EDB_RA_W{1'b0}};
            ras_n_q     <= 2'b11;
            cas_n_q     <= 1'b1;
            we_n_q      <= 4'hf;
            ram_wdata_q <= {`EDB_WORD_W{1'b0}};
            selected_q  <= 1'b0;
            busy_q      <= 1'b0;
            rd_data_q   <= {`EDB_DATA_W{1'b0}};
            rd_valid_q  <= 1'b0;
            rd_err_q    <= 1'b0;
            done_q      <= 1'b0;
            row_q       <= {`EDB_RA_W{1'b0}};
            col_q       <= {`EDB_RA_W{1'b0}};
            bank_q      <= 1'b0;
            wsel_q      <= 1'b0;
            bsel_q      <= 1'b0;
            wr_q        <= 1'b0;
            byte_q      <= 1'b0;
            pmi_q       <= 1'b0;
            wdat_q      <= {`EDB_DATA_W{1'b0}};
            lat_e_q     <= {`EDB_WORD_W{1'b0}};
            lat_o_q     <= {`EDB_WORD_W{1'b0}};
        end else begin
            // pulses default low
            rd_valid_q <= 1'b0;
            done_q     <= 1'b0;
            case (st_q)
                // wait for an address on this board
                S_IDLE: begin
                    if (req_start && hit_w) begin
                        row_q      <= off_w[`EDB_ROW_LSB+8:`EDB_ROW_LSB]; // [RQ4]
                        col_q      <= off_w[`EDB_COL_LSB+8:`EDB_COL_LSB]; // [RQ4]
                        bank_q     <= off_w[`EDB_BANK_BIT];               // [RQ8]
                        wsel_q     <= req_addr[`EDB_WORD_BIT];
                        bsel_q     <= req_addr[`EDB_BYTE_BIT];
                        wr_q       <= req_write;
                        byte_q     <= req_write & req_byte;
                        pmi_q      <= req_pmi;
                        wdat_q     <= req_wdata;
                        ram_addr_q <= off_w[`EDB_ROW_LSB+8:`EDB_ROW_LSB];
                        selected_q <= req_pmi; // [RQ2] [RQ3]
                        busy_q     <= 1'b1;
                        cnt_q      <= ROW_SET_CYC[CW-1:0];
                        st_q       <= S_ROW;
                    end
                end
                // row address settling on the ram pins
                S_ROW: begin
                    if (cnt_q <= 8'd1) begin
                        ras_n_q <= bank_q ? 2'b01 : 2'b10; // [RQ5] [RQ22]
                        cnt_q   <= ROW_HOLD_CYC[CW-1:0];
                        st_q    <= S_RAS;
                    end else begin
                        cnt_q <= cnt_q - 8'd1;
                    end
                end
                // row hold, then switch to column address
                S_RAS: begin
                    if (cnt_q <= 8'd1) begin
                        ram_addr_q <= col_q; // [RQ5]
                        if (wr_q && !byte_q) begin
                            ram_wdata_q <= {edb_gen(wdat_q), wdat_q}; // [RQ7] [RQ16]
                        end
                        cnt_q <= COL_SET_CYC[CW-1:0];
                        st_q  <= S_COL;
                    end else begin
                        cnt_q <= cnt_q - 8'd1;
                    end
                end
                // column address settling
                S_COL: begin
                    if (cnt_q <= 8'd1) begin
                        cas_n_q <= 1'b0; // [RQ6] [RQ22]
                        if (wr_q && !byte_q) begin
                            we_n_q <= blk_n_w; // [RQ16] [RQ17]
                        end
                        cnt_q <= CAS_ACC_CYC[CW-1:0];
                        st_q  <= (wr_q && !byte_q) ? S_WCAS : S_CAS;
                    end else begin
                        cnt_q <= cnt_q - 8'd1;
                    end
                end
                // read access time, both blocks driving
                S_CAS: begin
                    if (cnt_q <= 8'd1) begin
                        lat_e_q <= ram_rdata_even; // [RQ10] [RQ11]
                        lat_o_q <= ram_rdata_odd;  // [RQ10] [RQ11]
                        cas_n_q <= 1'b1;
                        st_q    <= S_LATCH;
                    end else begin
                        cnt_q <= cnt_q - 8'd1;
                    end
                end
                // deliver first word or start byte merge
                S_LATCH: begin
                    if (byte_q) begin
                        st_q <= S_MERGE; // [RQ18]
                    end else if (pmi_q && fst_w[`EDB_DATA_W]) begin
                        st_q <= S_FIX; // [RQ15]
                    end else begin
                        rd_data_q  <= fst_w[`EDB_DATA_W-1:0]; // [RQ13]
                        rd_err_q   <= fst_w[`EDB_DATA_W+1];
                        rd_valid_q <= 1'b1;
                        st_q       <= pmi_q ? S_SEC : S_PRE;
                        cnt_q      <= PRECHG_CYC[CW-1:0];
                    end
                end
                // one stall cycle for first-word correction
                S_FIX: begin
                    rd_data_q  <= fst_w[`EDB_DATA_W-1:0]; // [RQ15]
                    rd_err_q   <= fst_w[`EDB_DATA_W+1];
                    rd_valid_q <= 1'b1;
                    st_q       <= S_SEC;
                end
                // second pmi word, corrected without stall
                S_SEC: begin
                    rd_data_q  <= sec_w[`EDB_DATA_W-1:0]; // [RQ14] [RQ15]
                    rd_err_q   <= sec_w[`EDB_DATA_W+1];
                    rd_valid_q <= 1'b1;
                    cnt_q      <= PRECHG_CYC[CW-1:0];
                    st_q       <= S_PRE;
                end
                // merge byte, new checks, write back in page
                S_MERGE: begin
                    if (fst_w[`EDB_DATA_W+1]) begin
                        ram_wdata_q <= raw_w; // [RQ21]
                    end else begin
                        ram_wdata_q <= {edb_gen(mrg_w), mrg_w}; // [RQ18] [RQ19]
                    end
                    rd_err_q <= fst_w[`EDB_DATA_W+1];
                    cas_n_q  <= 1'b0;
                    we_n_q   <= blk_n_w; // [RQ19]
                    cnt_q    <= CAS_ACC_CYC[CW-1:0];
                    st_q     <= S_WCAS;
                end
                // write pulse under cas
                S_WCAS: begin
                    if (cnt_q <= 8'd1) begin
                        cas_n_q <= 1'b1;
                        we_n_q  <= 4'hf;
                        cnt_q   <= PRECHG_CYC[CW-1:0];
                        st_q    <= S_PRE;
                    end else begin
                        cnt_q <= cnt_q - 8'd1;
                    end
                end
                // release strobes, precharge
                S_PRE: begin
                    ras_n_q <= 2'b11;
                    cas_n_q <= 1'b1;
                    if (cnt_q <= 8'd1) begin
                        selected_q <= 1'b0;
                        busy_q     <= 1'b0;
                        done_q     <= 1'b1;
                        st_q       <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'd1;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule

// *** tb/edb_datapath_props.sv ***
// concurrent checks on the ports of the board datapath
`timescale 1ns/1ps
module edb_dp_props (
    input logic        clk_sys,
    input logic        rst_n,
    input logic        req_start,
    input logic        req_write,
    input logic        req_pmi,
    input logic [21:0] req_addr,
    input logic [21:0] start_addr,
    input logic [8:0]  ram_addr_q,
    input logic [1:0]  ras_n_q,
    input logic        cas_n_q,
    input logic [3:0]  we_n_q,
    input logic        selected_q,
    input logic        busy_q,
    input logic        rd_valid_q,
    input logic        done_q
);
    logic [21:0] off;    // offset from board start
    logic        hit;    // address lies on this board
    logic        take;   // request accepted this edge
    logic        pmi_q;  // protocol of the running cycle
    logic        wr_q;   // running cycle writes
    logic [1:0]  blk_q;  // {bank, word} block index
    logic [1:0]  vcnt_q; // words delivered so far
    assign off  = req_addr - start_addr;
    assign hit  = (req_addr >= start_addr) && !off[21];
    assign take = req_start && !busy_q && hit;
    ////////////////////////////////////////////////////////////////
    // remember what the running cycle asked for
    always @(posedge clk_sys) begin
        if (take) begin
            pmi_q  <= req_pmi;
            wr_q   <= req_write;
            blk_q  <= {off[20], off[1]};
            vcnt_q <= 2'h0;
        end else if (rd_valid_q) begin
            vcnt_q <= vcnt_q + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        take;
    endsequence
    sequence s_first_pmi;
        rd_valid_q && pmi_q && vcnt_q == 2'h0;
    endsequence
    a_accept_sel: assert property (s_take |=> busy_q && selected_q == pmi_q)
        else $error("select answer wrong at accept");
    a_miss_ignored: assert property (req_start && !busy_q && !hit |=> !busy_q)
        else $error("request off the board was accepted");
    a_row_stable: assert property (
        $fell(ras_n_q[0]) || $fell(ras_n_q[1]) |-> $stable(ram_addr_q))
        else $error("row strobe fell on a changing address");
    a_col_stable: assert property (
        $fell(cas_n_q) |-> $stable(ram_addr_q) && ras_n_q != 2'h3)
        else $error("column strobe fell on a changing address");
    a_ras_pair: assert property (ras_n_q != 2'h3 |-> ras_n_q == (blk_q[1] ? 2'h1 : 2'h2))
        else $error("row strobe on wrong block pair");
    a_we_block: assert property (
        we_n_q != 4'hf |-> we_n_q == ~(4'h1 << blk_q) && !cas_n_q && wr_q)
        else $error("write strobe on wrong block");
    a_word_count: assert property (
        done_q |-> vcnt_q == (wr_q ? 2'h0 : (pmi_q ? 2'h2 : 2'h1)))
        else $error("wrong number of words delivered");
    a_pmi_second: assert property (s_first_pmi |=> rd_valid_q)
        else $error("second word not back to back");
    a_done_bound: assert property (s_take |-> ##[2:40] done_q)
        else $error("cycle did not finish in time");
    a_idle_quiet: assert property (
        !busy_q && !done_q |-> ras_n_q == 2'h3 && cas_n_q && we_n_q == 4'hf)
        else $error("ram strobe active while idle");
endmodule

// *** tb/edb_ram_model.sv ***
// behavioural ram array for the four blocks of the board
`timescale 1ns/1ps
module edb_ram_model (
    input  logic        clk_sys,        // board clock
    input  logic [8:0]  ram_addr_q,     // multiplexed address
    input  logic [1:0]  ras_n_q,        // row strobes
    input  logic        cas_n_q,        // column strobe
    input  logic [3:0]  we_n_q,         // write strobes
    input  logic [21:0] ram_wdata_q,    // word to store
    input  logic [21:0] flip_even,      // error mask ordered by the bench
    input  logic [21:0] flip_odd,       // error mask ordered by the bench
    output logic [21:0] ram_rdata_even, // even block output
    output logic [21:0] ram_rdata_odd   // odd block output
);
    logic [21:0] mem [int];         // key {block, row, col}
    logic [8:0]  row_q;             // row taken at row strobe fall
    logic        ras_idle_q = 1'b1; // both row strobes were high
    logic        tog_q = 1'b0;      // junk pattern phase
    ////////////////////////////////////////////////////////////////
    // unwritten cells and released lines give a pattern, not old data
    function automatic logic [21:0] rd(input int k);
        return mem.exists(k) ? mem[k] : {22{tog_q}};
    endfunction
    always @(posedge clk_sys) begin
        tog_q      <= ~tog_q;
        ras_idle_q <= &ras_n_q;
        if (ras_idle_q && !(&ras_n_q)) begin
            row_q <= ram_addr_q;
        end
        for (int b = 0; b < 4; b++) begin
            if (!cas_n_q && !we_n_q[b]) begin
                mem[{b[1:0], row_q, ram_addr_q}] = ram_wdata_q;
            end
        end
        if (!cas_n_q && !(&ras_n_q)) begin
            ram_rdata_even <= rd({ras_n_q[0], 1'b0, row_q, ram_addr_q}) ^ flip_even;
            ram_rdata_odd  <= rd({ras_n_q[0], 1'b1, row_q, ram_addr_q}) ^ flip_odd;
        end else begin
            ram_rdata_even <= {22{tog_q}};
            ram_rdata_odd  <= ~{22{tog_q}};
        end
    end
endmodule

// *** tb/tb.sv ***
// self-checking bench for the ecc dram board datapath
`timescale 1ns/1ps
`define chk(nm, e, g) begin n_checks++; if ((e) !== (g)) begin err_total++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
    localparam logic [21:0] BASE = 22'h10_0000; // board start address
    localparam int          LAT  = 8;           // first word cycle, default counts
    logic        clk_sys, rst_n, req_start, req_write, req_byte, req_pmi;
    logic [21:0] req_addr, flip_even, flip_odd, ram_rdata_even, ram_rdata_odd, ram_wdata_q;
    logic [15:0] req_wdata, rd_data_q;
    logic [8:0]  ram_addr_q;
    logic [1:0]  ras_n_q;
    logic [3:0]  we_n_q;
    logic        cas_n_q, selected_q, busy_q, rd_valid_q, rd_err_q, done_q;
    int          err_total, n_checks, cyc;
    logic [15:0] got[$];   // words delivered
    int          pos[$];   // cycle of each word
    logic [15:0] dat [4];  // word held by each block
    edb_datapath i_edb_datapath (.clk_sys(clk_sys), .rst_n(rst_n), .req_start(req_start),
        .req_write(req_write), .req_byte(req_byte), .req_pmi(req_pmi), .req_addr(req_addr),
        .req_wdata(req_wdata), .start_addr(BASE), .ram_rdata_even(ram_rdata_even),
        .ram_rdata_odd(ram_rdata_odd), .ram_addr_q(ram_addr_q), .ras_n_q(ras_n_q),
        .cas_n_q(cas_n_q), .we_n_q(we_n_q), .ram_wdata_q(ram_wdata_q), .selected_q(selected_q),
        .busy_q(busy_q), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .rd_err_q(rd_err_q),
        .done_q(done_q));
    edb_ram_model i_edb_ram_model (.clk_sys(clk_sys), .ram_addr_q(ram_addr_q), .ras_n_q(ras_n_q),
        .cas_n_q(cas_n_q), .we_n_q(we_n_q), .ram_wdata_q(ram_wdata_q), .flip_even(flip_even),
        .flip_odd(flip_odd), .ram_rdata_even(ram_rdata_even), .ram_rdata_odd(ram_rdata_odd));
    ////////////////////////////////////////////////////////////////
    // expected stored word: data plus six check bits
    function automatic logic [21:0] enc(input logic [15:0] d);
        int         code [16] = '{3, 5, 6, 7, 9, 10, 11, 12, 13, 14, 15, 17, 18, 19, 20, 21};
        logic [5:0] c;
        c = 6'h0;
        for (int i = 0; i < 16; i++) if (d[i]) c[4:0] ^= code[i][4:0];
        c[5] = ^{d, c[4:0]};
        return {c, d};
    endfunction
    // model cell of a block at row 05a, column 1a5
    function automatic int key(input int b);
        return {b[1:0], 9'h05a, 9'h1a5};
    endfunction
    ////////////////////////////////////////////////////////////////
    // one bus cycle; collects delivered words until done
    task automatic op(input logic w, by, s, p, input int b, input logic [15:0] wd);
        int n;
        got.delete();
        pos.delete();
        @(posedge clk_sys);
        #1;
        {req_write, req_byte, req_pmi, req_wdata} = {w, by, p, wd};
        req_addr  = BASE + {1'b0, b[1], 9'h1a5, 9'h05a, b[0], s};
        req_start = 1'b1;
        @(posedge clk_sys);
        #1;
        req_start = 1'b0;
        for (n = 1; done_q !== 1'b1 && n < 60; n++) begin
            if (n == 1) `chk("selected", p, selected_q)
            if (rd_valid_q === 1'b1) begin
                got.push_back(rd_data_q);
                pos.push_back(n);
            end
            @(posedge clk_sys);
            #1;
        end
        `chk("done", 1'b1, done_q)
    endtask
    // word writes to all blocks, then both kinds of read
    task automatic t_word();
        for (int b = 0; b < 4; b++) begin
            dat[b] = 16'h1234 ^ 16'(16'h1111 * b);
            op(1, 0, 0, b[0], b, dat[b]);
        end
        for (int b = 0; b < 4; b++) begin
            `chk("stored", enc(dat[b]), i_edb_ram_model.mem[key(b)])
            op(0, 0, 0, 0, b, 16'h0);
            `chk("q word", dat[b], got[0])
            `chk("q count", 1, got.size())
            `chk("q time", LAT, pos[0])
            op(0, 0, 0, 1, b, 16'h0);
            `chk("p first", dat[b], got[0])
            `chk("p second", dat[b ^ 1], got[1])
        end
    endtask
    // read of block 0 with a correctable fault in one word
    task automatic rd_fix(input logic p, input logic [21:0] fe, fo, input int lat);
        {flip_even, flip_odd} = {fe, fo};
        op(0, 0, 0, p, 0, 16'h0);
        `chk("fix first", dat[0], got[0])
        `chk("fix time", lat, pos[0])
        if (p) `chk("fix second", dat[1], got[1])
        {flip_even, flip_odd} = 44'h0;
    endtask
    // byte merges, with clean, corrected and uncorrectable reads
    task automatic t_byte();
        logic [15:0] m;
        op(1, 1, 0, 0, 0, 16'habcd);
        m = {dat[0][15:8], 8'hcd};
        `chk("byte lo", enc(m), i_edb_ram_model.mem[key(0)])
        flip_even = 22'h00_0100;
        op(1, 1, 1, 1, 0, 16'h5a3c);
        m = {8'h5a, m[7:0]};
        `chk("byte hi", enc(m), i_edb_ram_model.mem[key(0)])
        flip_even = 22'h00_0003;
        op(1, 1, 0, 0, 0, 16'hffff);
        `chk("byte dbl", enc(m) ^ 22'h00_0003, i_edb_ram_model.mem[key(0)])
        `chk("dbl flag", 1'b1, rd_err_q)
        flip_even = 22'h0;
        op(0, 0, 0, 0, 0, 16'h0);
        `chk("dbl read", 1'b1, rd_err_q)
    endtask
    // request off the board must leave the block idle
    task automatic miss(input logic [21:0] a);
        @(posedge clk_sys);
        #1;
        {req_addr, req_write, req_start} = {a, 2'h1};
        @(posedge clk_sys);
        #1;
        req_start = 1'b0;
        repeat (3) begin
            `chk("miss busy", 1'b0, busy_q)
            @(posedge clk_sys);
            #1;
        end
    endtask
    task automatic end_sim();
        if (err_total == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            end_sim();
        end
    end
    initial begin
        {rst_n, req_start, req_write, req_byte, req_pmi} = 5'h0;
        {req_addr, req_wdata, flip_even, flip_odd} = 82'h0;
        repeat (20) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        t_word();
        rd_fix(0, 22'h00_0010, 22'h0, LAT);
        rd_fix(0, 22'h20_0000, 22'h0, LAT);
        rd_fix(1, 22'h00_0010, 22'h0, LAT + 1);
        rd_fix(1, 22'h0, 22'h00_8000, LAT);
        t_byte();
        miss(BASE - 22'h2);
        miss(BASE + 22'h20_0000);
        end_sim();
    end
endmodule
bind edb_datapath edb_dp_props i_edb_dp_props (.clk_sys(clk_sys), .rst_n(rst_n),
    .req_start(req_start), .req_write(req_write), .req_pmi(req_pmi), .req_addr(req_addr),
    .start_addr(start_addr), .ram_addr_q(ram_addr_q), .ras_n_q(ras_n_q), .cas_n_q(cas_n_q),
    .we_n_q(we_n_q), .selected_q(selected_q), .busy_q(busy_q), .rd_valid_q(rd_valid_q),
    .done_q(done_q));
